// File: wdog_pkg.sv
// shared constants and types for the watchdog timer
package wdog_pkg;
  // register port addresses
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_INT_STATUS = 4'h2;
  localparam logic [3:0] ADDR_INT_MASK = 4'h3;
  localparam logic [3:0] ADDR_COUNT = 4'h4;
  // control register layout: prescale in [5:1], software enable in [0]
  localparam int PS_LSB = 1;
  localparam int PS_W = 5;
  localparam logic [4:0] PS_DEFAULT = 5'h0B; // 2^11 ms, about two seconds
  localparam logic [4:0] PS_MAX = 5'h12; // 2^18 ms, about 256 seconds
  // status bits
  localparam int ST_EXPIRY = 0;
  localparam int ST_SLEEPENTRY = 1;
  localparam int ST_WDRESET = 2;
  localparam int ST_ACTIVE = 3;
  // interrupt event bits
  localparam int EV_TIMEOUT = 0;
  localparam int EV_WAKE = 1;
  localparam int EV_W = 2;
  // mode configuration codes
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_SW = 2'h1;
  localparam logic [1:0] MODE_NOSLEEP = 2'h2;
  localparam logic [1:0] MODE_ON = 2'h3;
  // timing: the slow oscillator and the 1 ms base tick
  localparam int LFOSC_KHZ = 31;
  localparam int TICK_MS = 1;
  localparam int TICK_LFCYCLES = LFOSC_KHZ * TICK_MS;
  localparam int CNT_W = 19;
  localparam int DATA_W = 8;
endpackage

// File: wdog_tick_if.sv
// carries the base tick between the divider and the watchdog core
`timescale 1ns/10ps
interface wdog_tick_if;
  logic lfEdge;
  logic tick;
  logic tickClear;
  modport divider (input lfEdge, input tickClear, output tick);
  modport core (output lfEdge, output tickClear, input tick);
endinterface

// File: wdog_tick_divider.sv
// divides slow-oscillator edges down to the 1 ms base tick
`timescale 1ns/10ps
module wdog_tick_divider
  import wdog_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  wdog_tick_if.divider tk
);
  logic [5:0] divCount_reg;
  logic [5:0] divCount_next;
  logic tick_reg;
  logic tick_next;
  localparam logic [5:0] DIV_LAST = 6'(TICK_LFCYCLES - 1);

  // count oscillator edges; a clear restarts the partial tick too
  always_comb
  begin
    divCount_next = divCount_reg;
    tick_next = 1'b0;
    if (tk.tickClear)
      divCount_next = 6'h00;
    else if (tk.lfEdge)
    begin
      if (divCount_reg == DIV_LAST)
      begin
        divCount_next = 6'h00;
        tick_next = 1'b1;
      end
      else
        divCount_next = divCount_reg + 6'h01;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      divCount_reg <= 6'h00;
      tick_reg <= 1'b0;
    end
    else
    begin
      divCount_reg <= divCount_next;
      tick_reg <= tick_next;
    end
  end

  assign tk.tick = tick_reg;
endmodule

// File: watchdog_timer.sv
// watchdog timer core with register port and interrupt
`timescale 1ns/10ps
// Summary of operation
// - counts 1 ms ticks from slow oscillator
// - mode 11: always active, also in sleep
// - mode 10: active awake, off in sleep
// - mode 01 follows software enable; 00 off
// - prescale field picks 1 ms to 256 s
// - reset default prescale gives two seconds
// - clear on reset, instruction, osc fail, disable
// - clear on sleep entry and exit
// - held clear while start-up timer runs
// - crystal wake: clear until start-up ends
// - frequency divider change leaves counter alone
// - sleep time-out wakes, no reset
// - time-out updates expiry, sleep flags; reset flag only when awake
module watchdog_timer
  import wdog_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic lfOscEdge,
  input wire logic [1:0] wdogModeCfg,
  input wire logic sleepMode,
  input wire logic sleepEnter,
  input wire logic sleepExit,
  input wire logic clearWdogInstr,
  input wire logic oscFail,
  input wire logic oscStartupRunning,
  input wire logic oscFreqSelectChange,
  input wire logic [3:0] addr,
  input wire logic [DATA_W-1:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  output logic [DATA_W-1:0] rdData,
  output logic wdogResetReq,
  output logic wakeReq,
  output logic irq
);
  wdog_tick_if tk();

  logic swEnable_reg, swEnable_next;
  logic [PS_W-1:0] prescale_reg, prescale_next;
  logic [CNT_W-1:0] count_reg, count_next;
  logic expiry_reg, expiry_next;
  logic sleepFlag_reg, sleepFlag_next;
  logic wdReset_reg, wdReset_next;
  logic [EV_W-1:0] intStatus_reg, intStatus_next;
  logic [EV_W-1:0] intMask_reg, intMask_next;
  logic [DATA_W-1:0] rdData_reg, rdData_next;
  logic resetReq_reg, resetReq_next;
  logic wake_reg, wake_next;
  logic irq_reg, irq_next;
  logic active;
  logic holdClear;
  logic timeout;
  logic [CNT_W-1:0] limit;
  logic [EV_W-1:0] events;

  wdog_tick_divider u_div (
    .core_clk(core_clk),
    .rst(rst),
    .tk(tk)
  );

  // mode decode from configuration, software enable and sleep
  always_comb
  begin
    unique case (wdogModeCfg)
      MODE_ON: active = 1'b1;
      MODE_NOSLEEP: active = !sleepMode;
      MODE_SW: active = swEnable_reg;
      MODE_OFF: active = 1'b0;
    endcase
  end

  // every clearing source; divider changes are deliberately absent
  assign holdClear = !active || clearWdogInstr || oscFail
    || sleepEnter || sleepExit
    || oscStartupRunning;
  assign tk.lfEdge = lfOscEdge;
  assign tk.tickClear = holdClear || timeout;

  // terminal count is 2^n base ticks
  assign limit = CNT_W'(1) << prescale_reg;
  assign timeout = active && !holdClear && tk.tick
    && (count_reg == limit - CNT_W'(1));

  // counter: cleared by any clearing source and by its own time-out
  always_comb
  begin
    count_next = count_reg;
    if (holdClear || timeout)
      count_next = '0;
    else if (tk.tick)
      count_next = count_reg + CNT_W'(1);
  end

  // time-out effects: reset awake, wake in sleep, status flags
  always_comb
  begin
    resetReq_next = timeout && !sleepMode;
    wake_next = timeout && sleepMode;
    expiry_next = expiry_reg;
    sleepFlag_next = sleepFlag_reg;
    wdReset_next = wdReset_reg;
    if (clearWdogInstr)
    begin
      expiry_next = 1'b0;
      sleepFlag_next = 1'b0;
    end
    // set after clear so a same-cycle sleep entry is not lost
    if (sleepEnter)
      sleepFlag_next = 1'b1;
    if (wrStrobe && addr == ADDR_STATUS && wrData[ST_WDRESET])
      wdReset_next = 1'b0;
    if (timeout)
    begin
      expiry_next = 1'b1;
      sleepFlag_next = sleepMode;
      if (!sleepMode)
        wdReset_next = 1'b1;
    end
  end

  // register writes, sticky events; set beats write-one clear
  assign events = {wake_next, resetReq_next};
  always_comb
  begin
    swEnable_next = swEnable_reg;
    prescale_next = prescale_reg;
    intMask_next = intMask_reg;
    intStatus_next = intStatus_reg;
    if (wrStrobe)
    begin
      unique case (addr)
        ADDR_CONTROL:
        begin
          swEnable_next = wrData[0];
          // values past the top of range clamp to 256 s
          if (wrData[PS_LSB +: PS_W] > PS_MAX)
            prescale_next = PS_MAX;
          else
            prescale_next = wrData[PS_LSB +: PS_W];
        end
        ADDR_INT_STATUS: intStatus_next = intStatus_reg & ~wrData[EV_W-1:0];
        ADDR_INT_MASK: intMask_next = wrData[EV_W-1:0];
        default: ;
      endcase
    end
    intStatus_next = intStatus_next | events;
    irq_next = |(intStatus_next & intMask_next);
  end

  // read mux; unmapped addresses read zero
  always_comb
  begin
    rdData_next = '0;
    if (rdStrobe)
    begin
      unique case (addr)
        ADDR_CONTROL:
          rdData_next = DATA_W'({prescale_reg, swEnable_reg});
        ADDR_STATUS:
        begin
          rdData_next[ST_EXPIRY] = expiry_reg;
          rdData_next[ST_SLEEPENTRY] = sleepFlag_reg;
          rdData_next[ST_WDRESET] = wdReset_reg;
          rdData_next[ST_ACTIVE] = active;
        end
        ADDR_INT_STATUS: rdData_next = DATA_W'(intStatus_reg);
        ADDR_INT_MASK: rdData_next = DATA_W'(intMask_reg);
        ADDR_COUNT: rdData_next = count_reg[DATA_W-1:0];
        default: rdData_next = '0;
      endcase
    end
  end

  // control and interrupt registers; reset restores defaults
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      swEnable_reg <= 1'b0;
      prescale_reg <= PS_DEFAULT;
      intStatus_reg <= '0;
      intMask_reg <= '0;
      irq_reg <= 1'b0;
    end
    else
    begin
      swEnable_reg <= swEnable_next;
      prescale_reg <= prescale_next;
      intStatus_reg <= intStatus_next;
      intMask_reg <= intMask_next;
      irq_reg <= irq_next;
    end
  end

  // time-out counter
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      count_reg <= '0;
    end
    else
    begin
      count_reg <= count_next;
    end
  end

  // time-out flags and outgoing pulses
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      expiry_reg <= 1'b0;
      sleepFlag_reg <= 1'b0;
      wdReset_reg <= 1'b0;
      resetReq_reg <= 1'b0;
      wake_reg <= 1'b0;
    end
    else
    begin
      expiry_reg <= expiry_next;
      sleepFlag_reg <= sleepFlag_next;
      wdReset_reg <= wdReset_next;
      resetReq_reg <= resetReq_next;
      wake_reg <= wake_next;
    end
  end

  // read data stand one cycle, zero otherwise
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rdData_reg <= '0;
    end
    else
    begin
      rdData_reg <= rdData_next;
    end
  end

  assign rdData = rdData_reg;
  assign wdogResetReq = resetReq_reg;
  assign wakeReq = wake_reg;
  assign irq = irq_reg;

  // named steps of a time-out
  sequence s_awake_timeout;
    timeout && !sleepMode;
  endsequence
  sequence s_sleep_timeout;
    timeout && sleepMode;
  endsequence

  // one clock domain, so the checks share clock and reset
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  a_mode_off_idle: assert property (
    (wdogModeCfg == MODE_OFF) |-> !active)
    else $error("watchdog active in mode off");
  a_always_on_mode: assert property (
    (wdogModeCfg == MODE_ON) |-> active)
    else $error("watchdog not active in mode on");
  a_nosleep_mode: assert property (
    (wdogModeCfg == MODE_NOSLEEP) |-> (active == !sleepMode))
    else $error("mode 10 sleep gating wrong");
  a_sw_mode: assert property (
    (wdogModeCfg == MODE_SW) |-> (active == swEnable_reg))
    else $error("software enable not followed");
  a_clear_sources: assert property (
    (clearWdogInstr || oscFail || !active) |=> (count_reg == '0))
    else $error("counter not cleared");
  a_sleep_edge_clear: assert property (
    (sleepEnter || sleepExit) |=> (count_reg == '0))
    else $error("counter not cleared at sleep edge");
  a_startup_hold: assert property (
    oscStartupRunning [*2] |-> (count_reg == '0))
    else $error("counter moved during start-up");
  a_divider_change: assert property (
    (oscFreqSelectChange && !holdClear && !tk.tick)
      |=> (count_reg == $past(count_reg)))
    else $error("counter moved on divider change");
  a_sleep_wake: assert property (
    s_sleep_timeout |=> (wakeReq && !wdogResetReq))
    else $error("sleep time-out did not wake");
  a_awake_reset: assert property (
    s_awake_timeout |=> (wdogResetReq && count_reg == '0))
    else $error("awake time-out did not reset");
  a_flags_update: assert property (
    s_awake_timeout |=> (expiry_reg && wdReset_reg && !sleepFlag_reg))
    else $error("time-out flags not updated");
  a_sleep_flags: assert property (
    s_sleep_timeout |=> (expiry_reg && sleepFlag_reg))
    else $error("sleep time-out flags not updated");
  a_prescale_range: assert property (
    prescale_reg <= PS_MAX)
    else $error("prescale beyond range");
  a_irq_level: assert property (
    $rose(wdogResetReq) && intMask_reg[EV_TIMEOUT] |-> irq)
    else $error("interrupt missing after time-out");
endmodule

// File: tb_top.sv
// self-checking testbench for the watchdog timer core
`timescale 1ns/10ps
module tb_top
  import wdog_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic lfOscEdge = 1'b0;
  logic [1:0] wdogModeCfg = MODE_ON;
  logic sleepMode = 1'b0;
  logic sleepEnter = 1'b0;
  logic sleepExit = 1'b0;
  logic clearWdogInstr = 1'b0;
  logic oscFail = 1'b0;
  logic oscStartupRunning = 1'b0;
  logic oscFreqSelectChange = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [DATA_W-1:0] wrData = 8'h00;
  logic wrStrobe = 1'b0;
  logic rdStrobe = 1'b0;
  logic [DATA_W-1:0] rdData;
  logic wdogResetReq;
  logic wakeReq;
  logic irq;
  int error_cnt = 0;
  int samples_checked = 0;
  int resetCnt = 0;
  int wakeCnt = 0;

  watchdog_timer u_dut (.core_clk(core_clk), .rst(rst),
    .lfOscEdge(lfOscEdge), .wdogModeCfg(wdogModeCfg),
    .sleepMode(sleepMode), .sleepEnter(sleepEnter),
    .sleepExit(sleepExit), .clearWdogInstr(clearWdogInstr),
    .oscFail(oscFail), .oscStartupRunning(oscStartupRunning),
    .oscFreqSelectChange(oscFreqSelectChange), .addr(addr),
    .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
    .rdData(rdData), .wdogResetReq(wdogResetReq), .wakeReq(wakeReq),
    .irq(irq));

  // 100 MHz core clock
  initial
  begin
    forever #5 core_clk = ~core_clk;
  end

  // tally outgoing pulses so latency need not be guessed exactly
  always @(posedge core_clk)
  begin
    if (wdogResetReq === 1'b1) resetCnt <= resetCnt + 1;
    if (wakeReq === 1'b1) wakeCnt <= wakeCnt + 1;
  end

  task automatic chk(input string name, input logic [7:0] exp,
                     input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge core_clk);
    wrStrobe <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge core_clk);
    rdStrobe <= 1'b0;
    #1 chk("rdData", exp, rdData);
    // next drive starts on a rising edge again
    @(posedge core_clk);
  endtask

  // slow-oscillator edges, one core cycle wide, one idle between
  task automatic edges(input int n);
    repeat (n)
    begin
      lfOscEdge <= 1'b1;
      @(posedge core_clk);
      lfOscEdge <= 1'b0;
      @(posedge core_clk);
    end
    repeat (4) @(posedge core_clk);
  endtask

  task automatic pulse(input int k);
    case (k)
      0: clearWdogInstr <= 1'b1;
      1: oscFail <= 1'b1;
      2: sleepEnter <= 1'b1;
      3: oscFreqSelectChange <= 1'b1;
      default: sleepExit <= 1'b1;
    endcase
    @(posedge core_clk);
    {clearWdogInstr, oscFail, sleepEnter} <= 3'h0;
    {oscFreqSelectChange, sleepExit} <= 2'h0;
    @(posedge core_clk);
  endtask

  // fresh start, n1 edges, optional event, n2 edges, count pulses
  task automatic trial(input int n1, input int src, input int n2,
                       input int expR, input int expW);
    int r0;
    int w0;
    pulse(0);
    r0 = resetCnt;
    w0 = wakeCnt;
    edges(n1);
    if (n2 > 0) chk("early reset", 8'h00, 8'(resetCnt - r0));
    if (src >= 0) pulse(src);
    edges(n2);
    chk("resets", 8'(expR), 8'(resetCnt - r0));
    chk("wakes", 8'(expW), 8'(wakeCnt - w0));
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // a hang is cut after well over the expected run time
  initial
  begin
    #400us;
    error_cnt++;
    print_verdict();
  end

  initial
  begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rd(ADDR_CONTROL, 8'h16);
    rd(4'hF, 8'h00);
    wr(ADDR_CONTROL, 8'h00);
    trial(31, -1, 0, 1, 0);
    rd(ADDR_STATUS, 8'h0D);
    wr(ADDR_STATUS, 8'h04);
    rd(ADDR_STATUS, 8'h09);
    rd(ADDR_INT_STATUS, 8'h01);
    #1 chk("irq masked", 8'h00, {7'h0, irq});
    @(posedge core_clk);
    wr(ADDR_INT_MASK, 8'h01);
    repeat (2) @(posedge core_clk);
    #1 chk("irq raised", 8'h01, {7'h0, irq});
    @(posedge core_clk);
    wr(ADDR_INT_STATUS, 8'h01);
    repeat (2) @(posedge core_clk);
    #1 chk("irq cleared", 8'h00, {7'h0, irq});
    @(posedge core_clk);
    trial(30, 0, 30, 0, 0);
    trial(30, 1, 30, 0, 0);
    trial(30, 3, 1, 1, 0);
    trial(30, 2, 30, 0, 0);
    trial(30, 4, 30, 0, 0);
    wr(ADDR_CONTROL, 8'h02);
    trial(61, -1, 1, 1, 0);
    edges(31);
    rd(ADDR_COUNT, 8'h01);
    wr(ADDR_CONTROL, 8'h00);
    sleepMode <= 1'b1;
    trial(31, -1, 0, 0, 1);
    rd(ADDR_STATUS, 8'h0F);
    wdogModeCfg <= MODE_NOSLEEP;
    trial(31, -1, 0, 0, 0);
    wdogModeCfg <= MODE_SW;
    wr(ADDR_CONTROL, 8'h01);
    trial(31, -1, 0, 0, 1);
    wr(ADDR_CONTROL, 8'h00);
    trial(31, -1, 0, 0, 0);
    sleepMode <= 1'b0;
    wr(ADDR_CONTROL, 8'h01);
    trial(31, -1, 0, 1, 0);
    wdogModeCfg <= MODE_OFF;
    trial(31, -1, 0, 0, 0);
    wdogModeCfg <= MODE_ON;
    oscStartupRunning <= 1'b1;
    trial(31, -1, 0, 0, 0);
    oscStartupRunning <= 1'b0;
    trial(31, -1, 0, 1, 0);
    wr(ADDR_CONTROL, 8'h02);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rd(ADDR_CONTROL, 8'h16);
    print_verdict();
  end
endmodule
